/* File: logic/ilod_pkg.sv */
// Package with register map, field layout and decode constants of the offset decoder.
`default_nettype none
package ilod_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [3:0]  ILOD_CTRL_OFS   = 4'h0;
  localparam logic [3:0]  ILOD_PTR_OFS    = 4'h4;
  localparam logic [3:0]  ILOD_BANK_OFS   = 4'h8;
  localparam logic [3:0]  ILOD_STAT_OFS   = 4'hC;
  // Field positions.
  localparam int          ILOD_EXT_BIT    = 0;
  localparam int          ILOD_STAT_IDX   = 12;
  localparam int          ILOD_STAT_DST   = 13;
  localparam int          ILOD_STAT_VLD   = 14;
  // Widths of the data address path.
  localparam int          ILOD_AW         = 12;
  localparam int          ILOD_BW         = 4;
  // Values after reset.
  localparam logic        ILOD_EXT_RST    = 1'b0;
  localparam logic [11:0] ILOD_PTR_RST    = 12'h000;
  localparam logic [3:0]  ILOD_BANK_RST   = 4'h0;
  // Decode boundaries.
  localparam logic [7:0]  ILOD_OFS_LIMIT  = 8'h5F;
  localparam logic [7:0]  ILOD_ACC_SPLIT  = 8'h80;
  localparam logic [3:0]  ILOD_ACC_LO_BNK = 4'h0;
  localparam logic [3:0]  ILOD_ACC_HI_BNK = 4'hF;
  localparam int          ILOD_NEW_INSTR  = 8;
endpackage : ilod_pkg
`default_nettype wire

/* File: logic/ilod_addr_if.sv */
// Interface between the bus-facing top and the operand address calculator.
`default_nettype none
interface ilod_addr_if;
  import ilod_pkg::*;
  logic                 ext_en;
  logic [ILOD_AW-1:0]   ptr;
  logic [ILOD_BW-1:0]   bank;
  logic [7:0]           file;
  logic                 access;
  logic [ILOD_AW-1:0]   addr;
  logic                 indexed;
  // Calculator side.
  modport calc (input ext_en, ptr, bank, file, access, output addr, indexed);
  // Top side.
  modport user (output ext_en, ptr, bank, file, access, input addr, indexed);
endinterface : ilod_addr_if
`default_nettype wire

/* File: logic/ilod_addr_calc.sv */
// Combinational operand address calculator for byte- and bit-oriented instructions.
`default_nettype none
module ilod_addr_calc
  import ilod_pkg::*;
(
  // Operand fields and pointer state.
  ilod_addr_if.calc     ai
);
  // Offset mode needs the extension on, the access bit clear and a small field.
  always_comb begin
    ai.indexed = ai.ext_en && !ai.access && (ai.file <= ILOD_OFS_LIMIT);
    if (ai.indexed) begin
      // The pointer wraps inside the data space; a pointer of zero gives the plain location.
      ai.addr = ILOD_AW'(ai.ptr + {4'h0, ai.file});
    end else if (ai.access) begin
      ai.addr = {ai.bank, ai.file};
    end else if (ai.file < ILOD_ACC_SPLIT) begin
      ai.addr = {ILOD_ACC_LO_BNK, ai.file};
    end else begin
      ai.addr = {ILOD_ACC_HI_BNK, ai.file};
    end
  end
endmodule : ilod_addr_calc
`default_nettype wire

/* File: logic/ilod_top.sv */
// Indexed literal offset operand decoder with a Wishbone register slave.
`default_nettype none
module ilod_top
  import ilod_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone classic slave.
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Operand fields from the instruction decoder.
  input  wire logic                dec_valid_i,
  input  wire logic [7:0]          dec_file_i,
  input  wire logic                dec_access_i,
  input  wire logic                dec_dest_i,
  // Resolved operand toward the data memory address path.
  output logic                     op_valid_o,
  output logic      [ILOD_AW-1:0]  op_addr_o,
  output logic                     op_to_file_o,
  output logic                     op_indexed_o,
  // Extended instruction decode enable.
  output logic                     ext_instr_en_o
);

  typedef struct packed {
    logic               ext_en;
    logic [ILOD_AW-1:0] ptr;
    logic [ILOD_BW-1:0] bank;
    logic               ack;
    logic [31:0]        rdata;
    logic               op_valid;
    logic [ILOD_AW-1:0] op_addr;
    logic               op_to_file;
    logic               op_indexed;
  } ilod_state_s;

  ilod_state_s st_r;
  ilod_state_s st_nxt;
  logic        wr_take;
  logic        req;

  ilod_addr_if ai ();

  // Present the live operand and pointer state to the calculator.
  assign ai.ext_en = st_r.ext_en;
  assign ai.ptr    = st_r.ptr;
  assign ai.bank   = st_r.bank;
  assign ai.file   = dec_file_i;
  assign ai.access = dec_access_i;

  ilod_addr_calc u_calc (
    .ai (ai.calc)
  );

  // A request is answered one cycle later; the write lands on the acknowledged edge.
  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_take = req && wb_we_i && st_r.ack;

  // Next-state logic for the bus slave and the operand output stage.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = req && !st_r.ack;
    st_nxt.rdata = 32'h0000_0000;
    if (req && !wb_we_i && !st_r.ack) begin
      case (wb_adr_i)
        ILOD_CTRL_OFS: st_nxt.rdata[ILOD_EXT_BIT] = st_r.ext_en;
        ILOD_PTR_OFS:  st_nxt.rdata[ILOD_AW-1:0]  = st_r.ptr;
        ILOD_BANK_OFS: st_nxt.rdata[ILOD_BW-1:0]  = st_r.bank;
        ILOD_STAT_OFS: begin
          st_nxt.rdata[ILOD_AW-1:0]  = st_r.op_addr;
          st_nxt.rdata[ILOD_STAT_IDX] = st_r.op_indexed;
          st_nxt.rdata[ILOD_STAT_DST] = st_r.op_to_file;
          st_nxt.rdata[ILOD_STAT_VLD] = st_r.op_valid;
        end
        default:       st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Writes honour byte lanes; unmapped or status writes are acknowledged and dropped.
    if (wr_take) begin
      case (wb_adr_i)
        ILOD_CTRL_OFS: begin
          if (wb_sel_i[0]) st_nxt.ext_en = wb_dat_i[ILOD_EXT_BIT];
        end
        ILOD_PTR_OFS: begin
          if (wb_sel_i[0]) st_nxt.ptr[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) st_nxt.ptr[ILOD_AW-1:8] = wb_dat_i[ILOD_AW-1:8];
        end
        ILOD_BANK_OFS: begin
          if (wb_sel_i[0]) st_nxt.bank = wb_dat_i[ILOD_BW-1:0];
        end
        default: st_nxt.ptr = st_r.ptr;
      endcase
    end
    // Every instruction class with an access bit goes through the same decode path.
    st_nxt.op_valid = dec_valid_i;
    if (dec_valid_i) begin
      st_nxt.op_addr    = ai.addr;
      st_nxt.op_indexed = ai.indexed;
      st_nxt.op_to_file = dec_dest_i;
    end
  end

  // Single state register; reset is synchronous.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r            <= '0;
      st_r.ext_en     <= ILOD_EXT_RST;
      st_r.ptr        <= ILOD_PTR_RST;
      st_r.bank       <= ILOD_BANK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign wb_ack_o       = st_r.ack;
  assign wb_dat_o       = st_r.rdata;
  assign op_valid_o     = st_r.op_valid;
  assign op_addr_o      = st_r.op_addr;
  assign op_to_file_o   = st_r.op_to_file;
  assign op_indexed_o   = st_r.op_indexed;
  assign ext_instr_en_o = st_r.ext_en;

  // Checks of the operand decode against its causes one cycle earlier.
  a_direct_access: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && !st_r.ext_en && !dec_access_i |=>
      op_addr_o == {($past(dec_file_i) < ILOD_ACC_SPLIT) ? ILOD_ACC_LO_BNK : ILOD_ACC_HI_BNK,
                    $past(dec_file_i)} && !op_indexed_o)
    else $error("direct access bank address wrong");

  a_offset_sum: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && st_r.ext_en && !dec_access_i && dec_file_i <= ILOD_OFS_LIMIT |=>
      op_indexed_o && op_addr_o == ILOD_AW'($past(st_r.ptr) + {4'h0, $past(dec_file_i)}))
    else $error("offset address not pointer plus field");

  a_large_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && dec_file_i > ILOD_OFS_LIMIT |=> !op_indexed_o)
    else $error("large field decoded as offset");

  a_ext_both: assert property (@(posedge clk_i) disable iff (rst_i)
    op_valid_o && op_indexed_o |-> $past(ext_instr_en_o))
    else $error("offset decode without extension enabled");

  a_uniform_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i |=> op_valid_o && op_indexed_o ==
      ($past(st_r.ext_en) && !$past(dec_access_i) && $past(dec_file_i) <= ILOD_OFS_LIMIT))
    else $error("offset decode not uniform");

  a_zero_pointer: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && st_r.ext_en && !dec_access_i && st_r.ptr == 12'h000 &&
    dec_file_i <= ILOD_OFS_LIMIT |=>
      op_addr_o == {ILOD_ACC_LO_BNK, $past(dec_file_i)})
    else $error("zero pointer does not map to access ram");

  a_dest_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i |=> op_to_file_o == $past(dec_dest_i))
    else $error("destination bit altered");

  a_bank_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && dec_access_i |=> op_addr_o == {$past(st_r.bank), $past(dec_file_i)})
    else $error("banked address wrong");

  // Register writes must land on the acknowledged edge only, lane by lane,
  // because the decode checks above trust the pointer and bank that software wrote.
  a_ptr_lanes: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_take && wb_adr_i == ILOD_PTR_OFS |=>
      st_r.ptr[7:0] == ($past(wb_sel_i[0]) ? $past(wb_dat_i[7:0]) : $past(st_r.ptr[7:0])) &&
      st_r.ptr[ILOD_AW-1:8] == ($past(wb_sel_i[1]) ? $past(wb_dat_i[ILOD_AW-1:8])
                                                     : $past(st_r.ptr[ILOD_AW-1:8])))
    else $error("pointer write lanes wrong");

  // Only a bus write may move the pointer; a stray update would shift every offset operand.
  a_ptr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_take && wb_adr_i == ILOD_PTR_OFS) |=> $stable(st_r.ptr))
    else $error("pointer changed without a write");

  a_bank_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_take && wb_adr_i == ILOD_BANK_OFS && wb_sel_i[0] |=>
      st_r.bank == $past(wb_dat_i[ILOD_BW-1:0]))
    else $error("bank write did not land");

  a_ext_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_take && wb_adr_i == ILOD_CTRL_OFS && wb_sel_i[0] |=>
      ext_instr_en_o == $past(wb_dat_i[ILOD_EXT_BIT]))
    else $error("extension enable write did not land");

  // The acknowledge is a single pulse, so a held request is never answered twice in a row.
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // Read data is zero outside the acknowledge cycle to keep a shared bus quiet.
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside acknowledge");

  // Main scenarios worth seeing.
  c_offset_used: cover property (@(posedge clk_i) disable iff (rst_i) op_valid_o && op_indexed_o);
  c_ext_banked:  cover property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && st_r.ext_en && dec_access_i);
  c_ext_large:   cover property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && st_r.ext_en && !dec_access_i && dec_file_i > ILOD_OFS_LIMIT);
  c_ptr_write:   cover property (@(posedge clk_i) disable iff (rst_i)
    wr_take && wb_adr_i == ILOD_PTR_OFS);

endmodule : ilod_top
`default_nettype wire

/* File: verification/ilod_mem_model.sv */
// Behavioural model of the data memory address path that consumes resolved operands.
`default_nettype none
module ilod_mem_model
  import ilod_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Resolved operand from the decoder.
  input  wire logic        op_valid_i,
  input  wire logic        op_to_file_i,
  // Access bookkeeping for the bench.
  output logic      [15:0] acc_cnt_o,
  output logic      [15:0] wr_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cells are not modelled, since only the number of accesses matters to the bench.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_cnt_o <= 16'h0000;
      wr_cnt_o  <= 16'h0000;
    end else if (op_valid_i) begin
      acc_cnt_o <= acc_cnt_o + 16'h0001;
      wr_cnt_o  <= wr_cnt_o + {15'h0000, op_to_file_i};
    end
  end
endmodule : ilod_mem_model
`default_nettype wire

/* File: verification/ilod_top_tb.sv */
// Self-checking bench of the offset decoder through its bus and decode ports.
`default_nettype none
module ilod_top_tb
  import ilod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dec_valid_i;
  logic        dec_access_i, dec_dest_i, op_valid_o, op_to_file_o, op_indexed_o, ext_instr_en_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [7:0]  dec_file_i;
  logic [7:0]  files [5] = '{8'h00, 8'h5F, 8'h60, 8'h80, 8'hFF};
  logic [11:0] op_addr_o;
  logic [15:0] acc_cnt, wr_cnt;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          num_errors, check_count, n_ops;
  // The design and the memory path model that consumes its operands.
  ilod_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .dec_valid_i, .dec_file_i, .dec_access_i, .dec_dest_i,
    .op_valid_o, .op_addr_o, .op_to_file_o, .op_indexed_o, .ext_instr_en_o);
  ilod_mem_model mem (.clk_i, .rst_i, .op_valid_i(op_valid_o), .op_to_file_i(op_to_file_o),
    .acc_cnt_o(acc_cnt), .wr_cnt_o(wr_cnt));
  // Clock of 8 ns period.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; the request stands unchanged until ack is sampled, then drops.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, dat};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t bus acknowledge missing", $time);
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb
  // Expected indexed flag and address; the sum wraps in 12 bits like the address path.
  function automatic logic [12:0] expect_op(input logic e, input logic [11:0] p,
                                            input logic [7:0] f, input logic a);
    if (e && !a && f <= ILOD_OFS_LIMIT) return {1'b1, p + {4'h0, f}};
    if (a) return {1'b0, 4'h3, f};
    return {1'b0, (f < ILOD_ACC_SPLIT) ? ILOD_ACC_LO_BNK : ILOD_ACC_HI_BNK, f};
  endfunction : expect_op
  // One operand for one cycle, with the registered result checked a cycle later.
  task automatic dec(input logic e, input logic [11:0] p, input logic [7:0] f,
                     input logic a, input logic d);
    logic [12:0] ex;
    ex = expect_op(e, p, f, a);
    @(posedge clk_i);
    {dec_valid_i, dec_file_i, dec_access_i, dec_dest_i} <= {1'b1, f, a, d};
    @(posedge clk_i);
    dec_valid_i <= 1'b0;
    #1;
    n_ops++;
    chk({17'h00000, op_valid_o, op_indexed_o, op_to_file_o, op_addr_o},
        {17'h00000, 1'b1, ex[12], d, ex[11:0]});
  endtask : dec
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Main sequence: reset values, every mode crossed with every field class, bus corners.
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, dec_valid_i, dec_access_i, dec_dest_i} = 7'h40;
    {wb_adr_i, wb_sel_i, dec_file_i, wb_dat_i} = 48'h0;
    num_errors = 0;
    check_count = 0;
    n_ops = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 4'(i * 4), 4'hF, 32'h0);
      chk(rd, 32'h0);
    end
    wb(1'b1, ILOD_BANK_OFS, 4'hF, 32'h3);
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, ILOD_CTRL_OFS, 4'hF, 32'(e));
      for (int p = 0; p < 2; p++) begin
        wb(1'b1, ILOD_PTR_OFS, 4'hF, p ? 32'hFE0 : 32'h0);
        for (int k = 0; k < 10; k++) begin
          dec(e[0], p ? 12'hFE0 : 12'h0, files[k / 2], k[0], ~k[0]);
        end
      end
      chk({31'h0, ext_instr_en_o}, 32'(e));
    end
    wb(1'b1, ILOD_PTR_OFS, 4'h1, 32'hFFFF_FF25);
    dec(1'b1, 12'hF25, 8'h10, 1'b0, 1'b1);
    wb(1'b1, ILOD_STAT_OFS, 4'hF, 32'h0);
    wb(1'b0, ILOD_STAT_OFS, 4'hF, 32'h0);
    chk(rd, 32'h3F35);
    wb(1'b0, 4'h6, 4'hF, 32'h0);
    chk(rd, 32'h0);
    chk({acc_cnt, wr_cnt}, {16'(n_ops), 16'(n_ops / 2 + 1)});
    wrap_up();
  end
  // Cuts a hang short well beyond the roughly 130 cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : ilod_top_tb
`default_nettype wire
